// ==== core/serial_rx_defs.svh ====
`ifndef SERIAL_RX_DEFS_SVH
`define SERIAL_RX_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_PIR       8'h0c
`define IDX_RXCTL     8'h18
`define IDX_RXBUF     8'h1a
`define IDX_PIE       8'h8c
`define IDX_TXCTL     8'h98
`define IDX_BRG       8'h99
`define IDX_EVT       8'ha0
`define IDX_EVT_MASK  8'ha1

// peripheral_interrupt_flags / peripheral_interrupt_enables
`define PIR_RCV_FLAG  5
`define PIE_RCV_IE    5

// receive_status_control
`define RS_PORT_EN    7
`define RS_NINE_BIT   6
`define RS_SINGLE_RX  5
`define RS_CONT_RX    4
`define RS_ADDR_DET   3
`define RS_FRAME_ERR  2
`define RS_OVERRUN    1
`define RS_NINTH      0

// transmit_status_control
`define TS_CLK_SRC    7
`define TS_TX_NINE    6
`define TS_TX_EN      5
`define TS_SYNC       4
`define TS_HIGH_BAUD  2
`define TS_SHIFT_EMPTY 1
`define TS_TX_NINTH   0

// event status / mask bits
`define EVT_DONE      0
`define EVT_FRAME     1
`define EVT_OVERRUN   2
`define EVT_W         3

// reset values
`define RST_BYTE      8'h00
`define RST_TRANSMIT_STATUS_CONTROL     8'h02
`define RST_EVT       3'h0

// oversampling: sixteen sub-ticks per bit, decision in the middle
`define OVS_MID       4'h8
`define OVS_LAST      4'hf
`define BAUD_SLOW     11'h004
`define BAUD_FAST     11'h001

`endif

// ==== core/serial_rx_pkg.sv ====
package serial_rx_pkg;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_NINTH,
        RX_STOP
    } rx_state_e;

    typedef struct packed {
        logic       ninth;
        logic       bad_stop;
        logic [7:0] data;
    } rx_char_s;

endpackage : serial_rx_pkg

// ==== core/rx_char_if.sv ====
`timescale 1ns/1ns
interface rx_char_if import serial_rx_pkg::*; ();
    logic     push_valid;
    logic     push_ready;
    rx_char_s push_char;
    logic     pop_valid;
    logic     pop_ready;
    rx_char_s head_char;

    modport producer (
        output push_valid, push_char, pop_ready,
        input  push_ready, pop_valid, head_char
    );
    modport store (
        input  push_valid, push_char, pop_ready,
        output push_ready, pop_valid, head_char
    );
endinterface : rx_char_if

// ==== core/rx_char_store.sv ====
`timescale 1ns/1ns
module rx_char_store import serial_rx_pkg::*; #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // character stream
    rx_char_if.store bus
);
    if (DEPTH < 2) begin : g_bad_depth
        $error("rx_char_store needs DEPTH of at least 2");
    end

    localparam int CW = $clog2(DEPTH + 1);

    rx_char_s        mem_reg [DEPTH];
    logic [CW-1:0]   count_reg;
    logic            push;
    logic            pop;
    logic [CW-1:0]   wr_idx;

    assign push           = bus.push_valid & bus.push_ready;
    assign pop            = bus.pop_ready & bus.pop_valid;
    assign bus.push_ready = (count_reg != CW'(DEPTH));
    assign bus.pop_valid  = (count_reg != '0);
    // entry zero is the head, so read data always comes from a register
    assign bus.head_char  = mem_reg[0];
    assign wr_idx         = pop ? CW'(count_reg - 1'b1) : count_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= CW'(count_reg + 1'b1);
        end else if (pop && !push) begin
            count_reg <= CW'(count_reg - 1'b1);
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst_i) begin
                mem_reg[i] <= '0;
            end else if (push && CW'(i) == wr_idx) begin
                mem_reg[i] <= bus.push_char;
            end else if (pop && i < DEPTH - 1) begin
                mem_reg[i] <= mem_reg[(i + 1) % DEPTH];
            end
        end
    end
endmodule : rx_char_store

// ==== core/serial_receiver_address_detect.sv ====
// Behaviour
// R1 - completed character sets flag; irq only if enabled
// R2 - software configures divisor, mode, then enables reception
// R3 - ninth bit and errors shown in status register
// R4 - data buffer read returns low eight bits
// R5 - clearing continuous receive clears the error
// R6 - software sets nine-bit and address detect first
// R7 - address detect passes only address characters
// R8 - software clears address detect when addressed
// R9 - synchronous master is half duplex
// R10 - sync select plus port enable remaps pins
// R11 - clock source select drives clock line
// R12 - ninth bit one marks an address character
// R13 - two-deep buffer holds unread characters
// R14 - zero stop bit sets framing error, buffered
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "serial_rx_defs.svh"
module serial_receiver_address_detect import serial_rx_pkg::*; #(
    parameter int RX_DEPTH = 2
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // serial pins
    input  wire logic        rx_i,
    output logic             serial_clock_line_o,
    output logic             serial_clock_line_oe_o,
    output logic             tx_permit_o,
    // interrupt
    output logic             irq_o
);
    if (RX_DEPTH != 2) begin : g_bad_depth
        $error("receive buffer must be two deep");
    end

    rx_char_if chr ();

    rx_char_store #(.DEPTH(RX_DEPTH)) u_store (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bus   (chr.store)
    );

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
        return idx == reg_idx;
    endfunction : hit

    logic                rx_meta_reg;
    logic                rx_sync_reg;
    logic                ack_reg;
    logic [31:0]         dat_reg;
    logic [7:0]          pie_reg;
    logic                port_en_reg;
    logic                nine_bit_reg;
    logic                single_rx_reg;
    logic                cont_rx_reg;
    logic                addr_det_reg;
    logic                oerr_reg;
    logic                clk_src_reg;
    logic                tx_nine_reg;
    logic                tx_en_reg;
    logic                sync_reg;
    logic                high_baud_reg;
    logic                tx_ninth_reg;
    logic [7:0]          brg_reg;
    logic [`EVT_W-1:0]   evt_reg;
    logic [`EVT_W-1:0]   evt_mask_reg;
    logic [10:0]         baud_cnt_reg;
    rx_state_e           state_reg;
    logic [3:0]          sub_reg;
    logic [2:0]          bit_reg;
    logic [7:0]          shift_reg;
    logic                ninth_reg;
    logic                sclk_reg;
    logic                sclk_oe_reg;
    logic                tx_permit_reg;
    logic                irq_reg;

    logic                wb_req;
    logic                wr_en;
    logic                rd_en;
    logic [7:0]          idx;
    logic [7:0]          rdata;
    logic [10:0]         baud_limit;
    logic                baud_run;
    logic                tick;
    logic                rx_en;
    logic                done;
    logic                addr_drop;
    logic                overrun;
    logic                pushed;
    logic [`EVT_W-1:0]   evt_set;
    logic [`EVT_W-1:0]   evt_clr;

    // the line is asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= rx_i;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    assign wb_req = cyc_i & stb_i & ~ack_reg;
    assign wr_en  = wb_req & we_i & sel_i[0];
    assign rd_en  = wb_req & ~we_i;
    assign idx    = adr_i[9:2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_req;
        end
    end

    always_comb begin
        rdata = `RST_BYTE;
        if (hit(idx, `IDX_PIR)) begin
            rdata[`PIR_RCV_FLAG] = chr.pop_valid;                             // R1
        end else if (hit(idx, `IDX_RXCTL)) begin
            rdata = {port_en_reg, nine_bit_reg, single_rx_reg, cont_rx_reg,
                     addr_det_reg, chr.pop_valid & chr.head_char.bad_stop,   // R3
                     oerr_reg, chr.head_char.ninth};                         // R3
        end else if (hit(idx, `IDX_RXBUF)) begin
            rdata = chr.head_char.data;                                       // R4
        end else if (hit(idx, `IDX_PIE)) begin
            rdata = pie_reg;
        end else if (hit(idx, `IDX_TXCTL)) begin
            rdata = {clk_src_reg, tx_nine_reg, tx_en_reg, sync_reg, 1'b0,
                     high_baud_reg, 1'b1, tx_ninth_reg};
        end else if (hit(idx, `IDX_BRG)) begin
            rdata = brg_reg;
        end else if (hit(idx, `IDX_EVT)) begin
            rdata = {5'h00, evt_reg};
        end else if (hit(idx, `IDX_EVT_MASK)) begin
            rdata = {5'h00, evt_mask_reg};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            dat_reg <= {24'h00_0000, rdata};
        end
    end

    // reading the data buffer advances the two-deep buffer
    assign chr.pop_ready = rd_en & hit(idx, `IDX_RXBUF);                    // R4

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pie_reg       <= `RST_BYTE;
            port_en_reg   <= 1'b0;
            nine_bit_reg  <= 1'b0;
            single_rx_reg <= 1'b0;
            cont_rx_reg   <= 1'b0;
            addr_det_reg  <= 1'b0;
        end else if (wr_en && hit(idx, `IDX_PIE)) begin
            pie_reg <= dat_i[7:0];
        end else if (wr_en && hit(idx, `IDX_RXCTL)) begin
            port_en_reg   <= dat_i[`RS_PORT_EN];
            nine_bit_reg  <= dat_i[`RS_NINE_BIT];
            single_rx_reg <= dat_i[`RS_SINGLE_RX];
            cont_rx_reg   <= dat_i[`RS_CONT_RX];
            addr_det_reg  <= dat_i[`RS_ADDR_DET];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_src_reg   <= 1'b0;
            tx_nine_reg   <= 1'b0;
            tx_en_reg     <= 1'b0;
            sync_reg      <= 1'b0;
            high_baud_reg <= 1'b0;
            tx_ninth_reg  <= 1'b0;
            brg_reg       <= `RST_BYTE;
            evt_mask_reg  <= `RST_EVT;
        end else if (wr_en && hit(idx, `IDX_TXCTL)) begin
            clk_src_reg   <= dat_i[`TS_CLK_SRC];
            tx_nine_reg   <= dat_i[`TS_TX_NINE];
            tx_en_reg     <= dat_i[`TS_TX_EN];
            sync_reg      <= dat_i[`TS_SYNC];
            high_baud_reg <= dat_i[`TS_HIGH_BAUD];
            tx_ninth_reg  <= dat_i[`TS_TX_NINTH];
        end else if (wr_en && hit(idx, `IDX_BRG)) begin
            brg_reg <= dat_i[7:0];
        end else if (wr_en && hit(idx, `IDX_EVT_MASK)) begin
            evt_mask_reg <= dat_i[`EVT_W-1:0];
        end
    end

    // baud prescaler: one tick per sixteenth of a bit in async mode
    assign baud_limit = 11'((11'({3'h0, brg_reg}) + 11'h001) *
                        ((high_baud_reg | sync_reg) ? `BAUD_FAST : `BAUD_SLOW)
                        - 11'h001);
    assign baud_run   = port_en_reg & (cont_rx_reg | single_rx_reg | tx_en_reg);
    assign tick       = baud_run & (baud_cnt_reg == baud_limit);

    always_ff @(posedge clk_i) begin
        if (rst_i || !baud_run || tick) begin
            baud_cnt_reg <= 11'h000;
        end else begin
            baud_cnt_reg <= 11'(baud_cnt_reg + 11'h001);
        end
    end

    // sync mode (either role) inhibits the async receiver
    assign rx_en = port_en_reg & cont_rx_reg & ~sync_reg & ~oerr_reg;   // R9

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_en) begin
            state_reg <= RX_IDLE;                                        // R5
            sub_reg   <= 4'h0;
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
            ninth_reg <= 1'b0;
        end else if (state_reg == RX_IDLE) begin
            if (!rx_sync_reg) begin
                state_reg <= RX_START;
                sub_reg   <= 4'h0;
                ninth_reg <= 1'b0;
            end
        end else if (tick) begin
            sub_reg <= 4'(sub_reg + 4'h1);
            unique case (state_reg)
                RX_START: begin
                    // a glitch shorter than half a bit is not a start bit
                    if (sub_reg == `OVS_MID && rx_sync_reg) begin
                        state_reg <= RX_IDLE;
                    end else if (sub_reg == `OVS_LAST) begin
                        state_reg <= RX_DATA;
                        bit_reg   <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (sub_reg == `OVS_MID) begin
                        shift_reg <= {rx_sync_reg, shift_reg[7:1]};
                    end
                    if (sub_reg == `OVS_LAST) begin
                        if (bit_reg == 3'h7) begin
                            state_reg <= nine_bit_reg ? RX_NINTH : RX_STOP;
                        end
                        bit_reg <= 3'(bit_reg + 3'h1);
                    end
                end
                RX_NINTH: begin
                    if (sub_reg == `OVS_MID) begin
                        ninth_reg <= rx_sync_reg;
                    end
                    if (sub_reg == `OVS_LAST) begin
                        state_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // back to idle at mid stop bit so the next start is seen
                    if (sub_reg == `OVS_MID) begin
                        state_reg <= RX_IDLE;
                    end
                end
                RX_IDLE: begin
                end
            endcase
        end
    end

    assign done      = rx_en & tick & (state_reg == RX_STOP) & (sub_reg == `OVS_MID);
    assign addr_drop = addr_det_reg & nine_bit_reg & ~ninth_reg;          // R7 R12
    assign overrun   = done & ~addr_drop & ~chr.push_ready;               // R13
    assign pushed    = chr.push_valid & chr.push_ready;

    assign chr.push_valid = done & ~addr_drop;                             // R7
    assign chr.push_char  = '{ninth: ninth_reg, bad_stop: ~rx_sync_reg,   // R14
                              data: shift_reg};

    // the error holds off reception until continuous receive is toggled
    always_ff @(posedge clk_i) begin
        if (rst_i || !cont_rx_reg) begin
            oerr_reg <= 1'b0;                                            // R5
        end else if (overrun) begin
            oerr_reg <= 1'b1;                                            // R13
        end
    end

    always_comb begin
        evt_set = `RST_EVT;
        evt_set[`EVT_DONE]    = pushed;
        evt_set[`EVT_FRAME]   = pushed & chr.push_char.bad_stop;
        evt_set[`EVT_OVERRUN] = overrun;
        evt_clr = (wr_en && hit(idx, `IDX_EVT)) ? dat_i[`EVT_W-1:0] : `RST_EVT;
    end

    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_reg <= `RST_EVT;
        end else begin
            evt_reg <= (evt_reg & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (chr.pop_valid & pie_reg[`PIE_RCV_IE])           // R1
                       | |(evt_reg & evt_mask_reg);
        end
    end

    // synchronous master clock on the former transmit pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_reg      <= 1'b0;
            sclk_oe_reg   <= 1'b0;
            tx_permit_reg <= 1'b0;
        end else begin
            sclk_oe_reg   <= port_en_reg & sync_reg & clk_src_reg;      // R10 R11
            tx_permit_reg <= port_en_reg & sync_reg & tx_en_reg        // R9
                             & ~(cont_rx_reg | single_rx_reg);
            if (!(port_en_reg && sync_reg && clk_src_reg && baud_run)) begin
                sclk_reg <= 1'b0;
            end else if (tick) begin
                sclk_reg <= ~sclk_reg;                                  // R11
            end
        end
    end

    assign dat_o                  = dat_reg;
    assign ack_o                  = ack_reg;
    assign serial_clock_line_o    = sclk_reg;
    assign serial_clock_line_oe_o = sclk_oe_reg;
    assign tx_permit_o            = tx_permit_reg;
    assign irq_o                  = irq_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_push_sets_flag: assert property (pushed |=> chr.pop_valid)                    // R1
        else $error("receive flag not set after character stored");
    a_irq_gated_on: assert property (chr.pop_valid && pie_reg[`PIE_RCV_IE] |=> irq_o) // R1
        else $error("enabled receive flag did not raise irq");
    a_irq_gated_off: assert property (evt_mask_reg == `RST_EVT && !pie_reg[`PIE_RCV_IE]
        ##1 evt_mask_reg == `RST_EVT && !pie_reg[`PIE_RCV_IE] |-> !irq_o)           // R1
        else $error("irq raised while all sources disabled");
    a_rxbuf_read: assert property (rd_en && hit(idx, `IDX_RXBUF)
        |=> ack_o && dat_o == {24'h00_0000, $past(chr.head_char.data)})            // R4
        else $error("data buffer read returned wrong byte");
    a_cont_clears: assert property (!cont_rx_reg |=> !oerr_reg && state_reg == RX_IDLE) // R5
        else $error("error not cleared by disabling continuous receive");
    a_addr_filter: assert property (done && addr_det_reg && nine_bit_reg && !ninth_reg
        |-> !chr.push_valid ##1 !$rose(evt_reg[`EVT_DONE]))                         // R7
        else $error("data character passed while address detect set");
    a_overrun_set: assert property (done && !addr_drop && !chr.push_ready
        |=> oerr_reg ##1 !rx_en)                                                   // R13
        else $error("overrun not flagged on full buffer");
    a_sync_rx_off: assert property ($rose(sync_reg) |=> state_reg == RX_IDLE [*2])   // R9
        else $error("async receiver active in sync mode");
    a_clock_drive: assert property (port_en_reg && sync_reg && clk_src_reg |=> sclk_oe_reg) // R11
        else $error("clock line not driven in sync master mode");
    a_frame_flag: assert property (pushed |=> evt_reg[`EVT_FRAME] == $past(!rx_sync_reg)
        || $past(evt_reg[`EVT_FRAME]))                                              // R14
        else $error("framing error not recorded with character");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held more than one cycle");

    c_char_stored: cover property (pushed);
    c_overrun: cover property (overrun);
    c_addr_dropped: cover property (done && addr_drop);
    c_irq_raised: cover property ($rose(irq_o));
endmodule : serial_receiver_address_detect

// ==== verif/serial_line_model.sv ====
`timescale 1ns/1ns
module serial_line_model #(
    parameter int BIT_CYCLES = 16
) (
    // clock
    input  wire logic clk_i,
    // serial line
    output logic      line_o
);
    // an idle uart line rests high
    initial line_o = 1'b1;

    // bit length in clocks; the bench may change it between frames
    int bit_cycles = BIT_CYCLES;

    task automatic put_bit(input logic b);
        line_o <= b;
        repeat (bit_cycles) @(posedge clk_i);
    endtask : put_bit

    // start, eight data bits lsb first, optional ninth, stop, then back to idle
    task automatic send(input logic [7:0] data, input logic nine_en, input logic ninth,
                        input logic stop);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            put_bit(data[i]);
        end
        if (nine_en) begin
            put_bit(ninth);
        end
        put_bit(stop);
        // a high stop bit already rests at idle; a low one needs an idle bit after it
        if (!stop) begin
            put_bit(1'b1);
        end
    endtask : send
endmodule : serial_line_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`include "serial_rx_defs.svh"
module testbench;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, rx_i;
    logic        serial_clock_line_o, serial_clock_line_oe_o, tx_permit_o, irq_o, p;
    logic [9:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic [7:0]  rd;
    int          fails, n_checks;

    serial_receiver_address_detect #(.RX_DEPTH(2)) u_serial_receiver_address_detect (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_i(rx_i), .serial_clock_line_o(serial_clock_line_o),
        .serial_clock_line_oe_o(serial_clock_line_oe_o), .tx_permit_o(tx_permit_o),
        .irq_o(irq_o));

    // divisor 0 with high speed baud gives sixteen clocks per bit
    serial_line_model #(.BIT_CYCLES(16)) u_serial_line_model (
        .clk_i(clk_i), .line_o(rx_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_reg

    // the caller reads the pin at an edge, before that edge's own updates land
    task automatic check_pin(input logic got_now, input logic exp);
        check_reg({7'h0, got_now}, {7'h0, exp});
    endtask : check_pin

    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [3:0] sel, output logic [7:0] rdv);
        int t;
        t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= {idx, 2'b00};
        sel_i <= sel;
        dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 100);
        if (t >= 100) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, ack_o, 1'b1);
        end
        rdv = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        wb(1'b1, idx, wd, 4'h1, rd);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, 4'h1, rd);
        check_reg(rd, exp);
    endtask : rdc

    // flag lands a few cycles after mid stop bit plus the line synchroniser
    task automatic settle();
        repeat (12) @(posedge clk_i);
    endtask : settle

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, fails);
    endtask : done

    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        give_verdict();
    end

    initial begin
        fails = 0;
        n_checks = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 10'h000;
        sel_i = 4'h0;
        dat_i = 32'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(`IDX_PIR, 8'h00);
        rdc(`IDX_RXCTL, 8'h00);
        rdc(`IDX_RXBUF, 8'h00);
        rdc(`IDX_PIE, 8'h00);
        rdc(`IDX_TXCTL, 8'h02);
        rdc(`IDX_BRG, 8'h00);
        rdc(8'h10, 8'h00);
        wr(`IDX_RXBUF, 8'hff);
        rdc(`IDX_RXBUF, 8'h00);
        wb(1'b1, `IDX_BRG, 8'hff, 4'h0, rd);
        rdc(`IDX_BRG, 8'h00);
        done("reset");

        wr(`IDX_BRG, 8'h00);
        wr(`IDX_TXCTL, 8'h04);
        wr(`IDX_PIE, 8'h20);
        wr(`IDX_RXCTL, 8'h90);
        u_serial_line_model.send(8'h5a, 1'b0, 1'b0, 1'b1);
        settle();
        check_pin(irq_o, 1'b1);
        rdc(`IDX_PIR, 8'h20);
        rdc(`IDX_RXCTL, 8'h90);
        rdc(`IDX_RXBUF, 8'h5a);
        rdc(`IDX_PIR, 8'h00);
        check_pin(irq_o, 1'b0);
        done("basic");

        u_serial_line_model.send(8'h11, 1'b0, 1'b0, 1'b1);
        u_serial_line_model.send(8'h22, 1'b0, 1'b0, 1'b1);
        u_serial_line_model.send(8'h33, 1'b0, 1'b0, 1'b1);
        settle();
        rdc(`IDX_RXCTL, 8'h92);
        rdc(`IDX_RXBUF, 8'h11);
        rdc(`IDX_RXBUF, 8'h22);
        rdc(`IDX_PIR, 8'h00);
        wr(`IDX_RXCTL, 8'h80);
        rdc(`IDX_RXCTL, 8'h80);
        wr(`IDX_RXCTL, 8'h90);
        u_serial_line_model.send(8'h66, 1'b0, 1'b0, 1'b0);
        settle();
        rdc(`IDX_RXCTL, 8'h94);
        rdc(`IDX_RXBUF, 8'h66);
        rdc(`IDX_RXCTL, 8'h90);
        done("overrun and framing");

        wr(`IDX_RXCTL, 8'hc0);
        wr(`IDX_RXCTL, 8'hc8);
        wr(`IDX_RXCTL, 8'hd8);
        u_serial_line_model.send(8'h77, 1'b1, 1'b0, 1'b1);
        u_serial_line_model.send(8'h3c, 1'b1, 1'b1, 1'b1);
        settle();
        rdc(`IDX_RXCTL, 8'hd9);
        rdc(`IDX_RXBUF, 8'h3c);
        rdc(`IDX_PIR, 8'h00);
        wr(`IDX_RXCTL, 8'hd0);
        u_serial_line_model.send(8'h44, 1'b1, 1'b0, 1'b1);
        settle();
        rdc(`IDX_RXCTL, 8'hd0);
        rdc(`IDX_RXBUF, 8'h44);
        done("address detect");

        wr(`IDX_RXCTL, 8'h90);
        wr(`IDX_PIE, 8'h00);
        wr(`IDX_EVT, 8'h07);
        wr(`IDX_EVT_MASK, 8'h00);
        u_serial_line_model.send(8'h55, 1'b0, 1'b0, 1'b1);
        settle();
        check_pin(irq_o, 1'b0);
        rdc(`IDX_EVT, 8'h01);
        wr(`IDX_EVT_MASK, 8'h01);
        check_pin(irq_o, 1'b1);
        wr(`IDX_EVT, 8'h01);
        check_pin(irq_o, 1'b0);
        rdc(`IDX_RXBUF, 8'h55);
        done("events");

        wr(`IDX_RXCTL, 8'h80);
        wr(`IDX_TXCTL, 8'hb4);
        rdc(`IDX_TXCTL, 8'hb6);
        check_pin(serial_clock_line_oe_o, 1'b1);
        check_pin(tx_permit_o, 1'b1);
        p = serial_clock_line_o;
        @(posedge clk_i);
        check_pin(serial_clock_line_o, ~p);
        wr(`IDX_RXCTL, 8'ha0);
        check_pin(tx_permit_o, 1'b0);
        rdc(`IDX_RXCTL, 8'ha0);
        wr(`IDX_RXCTL, 8'h80);
        check_pin(tx_permit_o, 1'b1);
        wr(`IDX_RXCTL, 8'h90);
        check_pin(tx_permit_o, 1'b0);
        done("sync master");

        // low speed: four times the clocks per bit at the same divisor
        wr(`IDX_TXCTL, 8'h00);
        wr(`IDX_RXCTL, 8'h90);
        u_serial_line_model.bit_cycles = 64;
        u_serial_line_model.send(8'ha5, 1'b0, 1'b0, 1'b1);
        settle();
        rdc(`IDX_RXCTL, 8'h90);
        rdc(`IDX_RXBUF, 8'ha5);
        done("low speed");
        give_verdict();
    end
endmodule : testbench
